// ---- core/mp_debug_consts.svh ----
// Offsets, field positions, reset values and widths of the debug registers.
`ifndef MP_DEBUG_CONSTS_SVH
`define MP_DEBUG_CONSTS_SVH

`define OFF_DATA_RAM_GRANT      8'h00
`define OFF_RUN_CONTROL_STATUS  8'h04
`define OFF_PROGRAM_COUNTER     8'h08
`define OFF_FAULT_DATA_ADDRESS  8'h0c
`define OFF_WATCH_ADDRESS       8'h10
`define OFF_EXCEPTION_PC        8'h14
`define OFF_EXCEPTION_CAUSE     8'h18
`define OFF_EXCEPTION_FLAGS     8'h1c
`define OFF_CYCLE_COUNTER       8'h20
`define OFF_BS_WATCH_ADDRESS    8'h24
`define OFF_BITS_IN_COUNTER     8'h28
`define OFF_BITS_OUT_COUNTER    8'h2c
`define OFF_INBOUND_MAILBOX     8'h30

`define RUN_BIT                 0
`define RELEASE_BIT             1
`define CAUSE_DELAY_BIT         31
`define MAILBOX_FULL_BIT        15

`define RST_GRANT               3'h0
`define RST_CONTROL             2'h0
`define RST_MAILBOX             16'h0000
`define NUM_EXC                 8
`define NUM_BANKS               3

`define EXC_LOAD_FAULT          5'h00
`define EXC_STORE_FAULT         5'h01

`endif

// ---- core/mp_debug_pkg.sv ----
// Types shared by the media processor debug register bank.
package mp_debug_pkg;

   // One load or store issued by the media processor scalar unit.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  bank;
      logic [31:0] addr;
   } ls_access_t;

   // Exception report from the media processor pipeline.
   typedef struct packed {
      logic [7:0]  events;
      logic [15:2] pc;
      logic        delay_slot;
      logic [31:0] data_addr;
   } exc_report_t;

   // One load or store issued by the bitstream processor.
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } bs_access_t;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ACCESS
   } bus_state_t;

endpackage : mp_debug_pkg

// ---- core/media_processor_debug_regs.sv ----
// Debug, control and status registers of the media processor.
//
// What this block does
// RULE_01 - Loads and stores to ungranted data RAM banks are ignored by RAM control.
// RULE_02 - Grant bits 0,1,2 enable banks A,B,C; all reset to zero.
// RULE_03 - DMA uses ungranted banks freely; granted banks stall DMA during loads/stores.
// RULE_04 - Control resets to 0x00; writing 0x00 halts and resets the processor.
// RULE_05 - Run bit: write 1 starts, write 0 halts, reads running state.
// RULE_06 - Control bit 1 low holds reset; high releases, then waits for run.
// RULE_07 - Software releases reset, sets run, then polls run for break stops.
// RULE_08 - PC write loads fetch counter; PC read returns decode counter.
// RULE_09 - Software reloads PC bits 15:2 each time it restarts the processor.
// RULE_10 - Load or store address fault captures the 32-bit data address.
// RULE_11 - Load/store addresses compared to watch bits 31:3; low bits read zero.
// RULE_12 - Exception PC bits 15:2 hold the faulting instruction; rest reads zero.
// RULE_13 - Cause holds code in bits 6:2 and delay-slot flag in bit 31.
// RULE_14 - Codes 0..7 name the eight exceptions; 8..31 are reserved.
// RULE_15 - Simultaneous exceptions record only the highest priority cause.
// RULE_16 - Sticky flag bits 0..7 per exception; software clears; 31:8 read zero.
// RULE_17 - No exception detection while any flag bit is set.
// RULE_18 - 32-bit cycle counter increments every clock with ce high, wraps, writable, resets zero.
// RULE_19 - Bitstream watchpoint compares bits 15:1, ignoring address bit 0.
// RULE_20 - 24-bit input counter counts 32-bit input FIFO transfers; writable.
// RULE_21 - 24-bit output counter counts 16-bit write buffer transfers; writable.
// RULE_22 - Mailbox write sets bit 15; bitstream read returns and clears it.
`timescale 1ns/100ps
`include "mp_debug_consts.svh"

module media_processor_debug_regs (
   // Clock, reset and freeze.
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       ce,
   // AHB-Lite slave.
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   // Media processor core.
   input  wire mp_debug_pkg::ls_access_t   ls,
   input  wire mp_debug_pkg::exc_report_t  exc,
   input  wire logic                       break_stop,
   input  wire logic [15:2]                decode_pc,
   output logic                            mp_run,
   output logic                            mp_reset_hold,
   output logic                            fetch_pc_load,
   output logic [15:2]                     fetch_pc,
   output logic                            watch_hit,
   // Data RAM control and DMA arbitration.
   input  wire logic [`NUM_BANKS-1:0]      dma_req,
   output logic [`NUM_BANKS-1:0]           dma_grant,
   output logic                            ram_rd_en,
   output logic                            ram_wr_en,
   // Bitstream processor.
   input  wire mp_debug_pkg::bs_access_t   bs_ls,
   input  wire logic                       bs_in_xfer,
   input  wire logic                       bs_out_xfer,
   input  wire logic                       bs_mbox_rd,
   output logic                            bs_watch_hit,
   output logic [15:0]                     bs_mbox_data
);

   mp_debug_pkg::bus_state_t bus_state_reg;
   logic [7:0]               addr_reg;
   logic                     write_reg;
   logic [2:0]               data_ram_grant_reg;
   logic [1:0]               control_reg;
   logic [31:0]              fault_addr_reg;
   logic [31:3]              watch_reg;
   logic [15:2]              epc_reg;
   logic [4:0]               cause_code_reg;
   logic                     cause_delay_reg;
   logic [7:0]               flags_reg;
   logic [7:0]               flags_next;
   logic [31:0]              cycle_reg;
   logic [15:1]              bs_watch_reg;
   logic [23:0]              in_count_reg;
   logic [23:0]              out_count_reg;
   logic [15:0]              mailbox_reg;
   logic                     acc_wr;
   logic                     acc_rd;
   logic                     detect;
   logic [31:0]              read_value;

   // True when the registered bus address equals the given offset.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Lowest set event code wins when several arrive together.
   function automatic logic [4:0] first_code(input logic [7:0] ev);
      first_code = 5'h00;
      for (int i = 7; i >= 0; i--) begin
         if (ev[i]) begin
            first_code = 5'(i);
         end
      end
   endfunction : first_code

   assign acc_wr = ce && (bus_state_reg == mp_debug_pkg::BUS_ACCESS)
                   && write_reg;
   assign acc_rd = ce && (bus_state_reg == mp_debug_pkg::BUS_ACCESS)
                   && !write_reg;
   assign detect = (flags_reg == 8'h00) && (exc.events != 8'h00); // RULE_17

   // Bus slave: one wait state, then registered read data, always OKAY.
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_state_reg <= mp_debug_pkg::BUS_IDLE;
         addr_reg      <= 8'h00;
         write_reg     <= 1'b0;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         hrdata        <= 32'h0000_0000;
      end else if (ce) begin
         case (bus_state_reg)
            mp_debug_pkg::BUS_IDLE: begin
               if (hsel && htrans[1] && hready) begin
                  addr_reg      <= {haddr[7:2], 2'b00};
                  write_reg     <= hwrite;
                  hreadyout     <= 1'b0;
                  bus_state_reg <= mp_debug_pkg::BUS_ACCESS;
               end
            end
            mp_debug_pkg::BUS_ACCESS: begin
               hrdata        <= write_reg ? 32'h0000_0000 : read_value;
               hreadyout     <= 1'b1;
               bus_state_reg <= mp_debug_pkg::BUS_IDLE;
            end
            default: begin
               bus_state_reg <= mp_debug_pkg::BUS_IDLE;
               hreadyout     <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer; unmapped offsets and undefined bits read zero.
   always_comb begin
      read_value = 32'h0000_0000;
      case (addr_reg)
         `OFF_DATA_RAM_GRANT:     read_value[2:0] = data_ram_grant_reg;
         `OFF_RUN_CONTROL_STATUS: read_value[1:0] = control_reg;
         `OFF_PROGRAM_COUNTER:    read_value[15:2] = decode_pc; // RULE_08
         `OFF_FAULT_DATA_ADDRESS: read_value = fault_addr_reg;
         `OFF_WATCH_ADDRESS:      read_value[31:3] = watch_reg; // RULE_11
         `OFF_EXCEPTION_PC:       read_value[15:2] = epc_reg; // RULE_12
         `OFF_EXCEPTION_CAUSE: begin
            read_value[6:2]              = cause_code_reg; // RULE_13
            read_value[`CAUSE_DELAY_BIT] = cause_delay_reg;
         end
         `OFF_EXCEPTION_FLAGS:    read_value[7:0] = flags_reg; // RULE_16
         `OFF_CYCLE_COUNTER:      read_value = cycle_reg;
         `OFF_BS_WATCH_ADDRESS:   read_value[15:1] = bs_watch_reg;
         `OFF_BITS_IN_COUNTER:    read_value[23:0] = in_count_reg;
         `OFF_BITS_OUT_COUNTER:   read_value[23:0] = out_count_reg;
         `OFF_INBOUND_MAILBOX:    read_value[15:0] = mailbox_reg;
         default:                 read_value = 32'h0000_0000;
      endcase
   end

   // Data RAM bank grants.
   always_ff @(posedge clk) begin
      if (rst) begin
         data_ram_grant_reg <= `RST_GRANT; // RULE_02
      end else if (acc_wr && hit(addr_reg, `OFF_DATA_RAM_GRANT)) begin
         data_ram_grant_reg <= hwdata[2:0]; // RULE_02
      end
   end

   // RAM strobes pass only for granted banks; bank 3 never exists.
   always_ff @(posedge clk) begin
      if (rst) begin
         ram_rd_en <= 1'b0;
         ram_wr_en <= 1'b0;
      end else if (ce) begin
         ram_rd_en <= ls.valid && !ls.write && (ls.bank != 2'h3)
                      && data_ram_grant_reg[ls.bank]; // RULE_01
         ram_wr_en <= ls.valid && ls.write && (ls.bank != 2'h3)
                      && data_ram_grant_reg[ls.bank]; // RULE_01
      end
   end

   // DMA may use a bank unless it is granted and a load or store is active.
   for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_dma
      always_ff @(posedge clk) begin
         if (rst) begin
            dma_grant[b] <= 1'b0;
         end else if (ce) begin
            dma_grant[b] <= dma_req[b]
                            && !(data_ram_grant_reg[b] && ls.valid); // RULE_03
         end
      end
   end

   // Run and reset-release control; a break stop clears the run bit.
   always_ff @(posedge clk) begin
      if (rst) begin
         control_reg <= `RST_CONTROL; // RULE_04
      end else if (acc_wr && hit(addr_reg, `OFF_RUN_CONTROL_STATUS)) begin
         control_reg <= hwdata[1:0]; // RULE_04 RULE_05 RULE_06
      end else if (ce && break_stop) begin
         control_reg[`RUN_BIT] <= 1'b0; // RULE_05
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mp_run        <= 1'b0;
         mp_reset_hold <= 1'b1;
      end else if (ce) begin
         mp_reset_hold <= !control_reg[`RELEASE_BIT]; // RULE_06
         mp_run        <= control_reg[`RUN_BIT]
                          && control_reg[`RELEASE_BIT]; // RULE_06
      end
   end

   // Program counter write loads the fetch stage.
   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_pc_load <= 1'b0;
         fetch_pc      <= 14'h0000;
      end else if (ce) begin
         fetch_pc_load <= acc_wr && hit(addr_reg, `OFF_PROGRAM_COUNTER);
         if (acc_wr && hit(addr_reg, `OFF_PROGRAM_COUNTER)) begin
            fetch_pc <= hwdata[15:2]; // RULE_08
         end
      end
   end

   // Watch addresses and match detection.
   always_ff @(posedge clk) begin
      if (rst) begin
         watch_reg    <= 29'h0000_0000;
         bs_watch_reg <= 15'h0000;
      end else begin
         if (acc_wr && hit(addr_reg, `OFF_WATCH_ADDRESS)) begin
            watch_reg <= hwdata[31:3];
         end
         if (acc_wr && hit(addr_reg, `OFF_BS_WATCH_ADDRESS)) begin
            bs_watch_reg <= hwdata[15:1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         watch_hit    <= 1'b0;
         bs_watch_hit <= 1'b0;
      end else if (ce) begin
         watch_hit    <= ls.valid && (ls.addr[31:3] == watch_reg); // RULE_11
         bs_watch_hit <= bs_ls.valid
                         && (bs_ls.addr[15:1] == bs_watch_reg); // RULE_19
      end
   end

   // Exception capture happens only while every flag is clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_addr_reg  <= 32'h0000_0000;
         epc_reg         <= 14'h0000;
         cause_code_reg  <= 5'h00;
         cause_delay_reg <= 1'b0;
      end else if (ce && detect) begin
         epc_reg         <= exc.pc; // RULE_12
         cause_code_reg  <= first_code(exc.events); // RULE_14 RULE_15
         cause_delay_reg <= exc.delay_slot; // RULE_13
         if (first_code(exc.events) == `EXC_LOAD_FAULT
             || first_code(exc.events) == `EXC_STORE_FAULT) begin
            fault_addr_reg <= exc.data_addr; // RULE_10
         end
      end
   end

   // Sticky flags: a detected event wins over a clearing write.
   always_comb begin
      flags_next = flags_reg;
      if (acc_wr && hit(addr_reg, `OFF_EXCEPTION_FLAGS)) begin
         flags_next = hwdata[7:0];
      end
      if (detect) begin
         flags_next = flags_next | exc.events; // RULE_16
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= 8'h00;
      end else if (ce) begin
         flags_reg <= flags_next; // RULE_16 RULE_17
      end
   end

   // Free-running and transfer counters; a write wins over a step.
   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_reg <= 32'h0000_0000;
      end else if (acc_wr && hit(addr_reg, `OFF_CYCLE_COUNTER)) begin
         cycle_reg <= hwdata;
      end else if (ce) begin
         cycle_reg <= cycle_reg + 32'h0000_0001; // RULE_18
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_count_reg  <= 24'h00_0000;
         out_count_reg <= 24'h00_0000;
      end else if (ce) begin
         if (acc_wr && hit(addr_reg, `OFF_BITS_IN_COUNTER)) begin
            in_count_reg <= hwdata[23:0];
         end else if (bs_in_xfer) begin
            in_count_reg <= in_count_reg + 24'h00_0001; // RULE_20
         end
         if (acc_wr && hit(addr_reg, `OFF_BITS_OUT_COUNTER)) begin
            out_count_reg <= hwdata[23:0];
         end else if (bs_out_xfer) begin
            out_count_reg <= out_count_reg + 24'h00_0001; // RULE_21
         end
      end
   end

   // Inbound mailbox; the write's set of bit 15 wins over a read's clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         mailbox_reg  <= `RST_MAILBOX;
         bs_mbox_data <= 16'h0000;
      end else if (ce) begin
         if (bs_mbox_rd) begin
            bs_mbox_data <= mailbox_reg; // RULE_22
         end
         if (acc_wr && hit(addr_reg, `OFF_INBOUND_MAILBOX)) begin
            mailbox_reg <= {1'b1, hwdata[14:0]}; // RULE_22
         end else if (bs_mbox_rd) begin
            mailbox_reg[`MAILBOX_FULL_BIT] <= 1'b0; // RULE_22
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ram_gate_off: assert property (ce && ls.valid && (ls.bank != 2'h3)
      && !data_ram_grant_reg[ls.bank] |=> !ram_rd_en && !ram_wr_en) // RULE_01
      else $error("ungranted bank access reached data RAM");
   a_dma_stall_ls: assert property (ce && ls.valid
      |=> (dma_grant & $past(data_ram_grant_reg)) == 3'h0) // RULE_03
      else $error("DMA granted a bank during a load or store");
   a_ctl_zero_halts: assert property (acc_wr
      && hit(addr_reg, `OFF_RUN_CONTROL_STATUS) && hwdata[1:0] == 2'h0
      ##1 ce |=> !mp_run && mp_reset_hold) // RULE_04
      else $error("writing zero did not halt and reset");
   a_break_clears_run: assert property (ce && break_stop
      && !(acc_wr && hit(addr_reg, `OFF_RUN_CONTROL_STATUS))
      |=> !control_reg[`RUN_BIT]) // RULE_05
      else $error("break stop left run bit set");
   a_pc_write_load: assert property (acc_wr
      && hit(addr_reg, `OFF_PROGRAM_COUNTER)
      |=> fetch_pc_load && fetch_pc == $past(hwdata[15:2])) // RULE_08
      else $error("program counter write did not load fetch stage");
   a_flags_block_cause: assert property (ce && flags_reg != 8'h00
      |=> $stable(cause_code_reg) && $stable(epc_reg)) // RULE_17
      else $error("exception captured while flags set");
   a_cause_priority: assert property (ce && detect && exc.events[0]
      |=> cause_code_reg == 5'h00 && flags_reg[0]) // RULE_15
      else $error("highest priority cause not recorded");
   a_counter_steps: assert property (ce
      && !(acc_wr && hit(addr_reg, `OFF_CYCLE_COUNTER))
      |=> cycle_reg == $past(cycle_reg) + 32'h0000_0001) // RULE_18
      else $error("cycle counter did not step");
   a_bs_watch_match: assert property (ce && bs_ls.valid
      && bs_ls.addr[15:1] == bs_watch_reg |=> bs_watch_hit) // RULE_19
      else $error("bitstream watch match missed");
   a_mailbox_magic: assert property (acc_wr
      && hit(addr_reg, `OFF_INBOUND_MAILBOX)
      |=> mailbox_reg[`MAILBOX_FULL_BIT]) // RULE_22
      else $error("mailbox write did not set bit 15");

   c_bus_read: cover property (acc_rd ##1 hreadyout);
   c_multi_exc: cover property (ce && detect && exc.events[0]
      && exc.events[3]);
   c_mailbox_cycle: cover property (acc_wr ##[1:20] (ce && bs_mbox_rd));

endmodule : media_processor_debug_regs

// ---- tb/mp_far_side.sv ----
// Behavioural model of the media and bitstream processors beside the bank.
`timescale 1ns/100ps

module mp_far_side (
   // Clock.
   input  wire logic                 clk,
   // Processor activity toward the register bank.
   output mp_debug_pkg::ls_access_t  ls,
   output mp_debug_pkg::exc_report_t exc,
   output mp_debug_pkg::bs_access_t  bs_ls,
   output logic                      break_stop,
   output logic                      bs_in_xfer,
   output logic                      bs_out_xfer,
   output logic                      bs_mbox_rd,
   // Levels.
   output logic [15:2]               decode_pc,
   output logic [2:0]                dma_req
);
   initial begin
      ls = '0;
      exc = '0;
      bs_ls = '0;
      {break_stop, bs_in_xfer, bs_out_xfer, bs_mbox_rd} = 4'h0;
      decode_pc = '0;
      dma_req = 3'h0;
   end

   task automatic levels(input logic [2:0] req, input logic [15:2] pc);
      @(posedge clk);
      dma_req <= req;
      decode_pc <= pc;
   endtask : levels

   // One cycle of activity; released fields then carry inverted garbage.
   task automatic step(input mp_debug_pkg::ls_access_t l,
                       input mp_debug_pkg::exc_report_t e,
                       input mp_debug_pkg::bs_access_t b,
                       input logic [3:0] p);
      @(posedge clk);
      ls <= l;
      exc <= e;
      bs_ls <= b;
      {break_stop, bs_in_xfer, bs_out_xfer, bs_mbox_rd} <= p;
      @(posedge clk);
      ls <= {1'b0, ~l.write, ~l.bank, ~l.addr};
      exc <= {8'h00, ~e.pc, ~e.delay_slot, ~e.data_addr};
      bs_ls <= {1'b0, ~b.addr};
      {break_stop, bs_in_xfer, bs_out_xfer, bs_mbox_rd} <= 4'h0;
   endtask : step
endmodule : mp_far_side

// ---- tb/media_processor_debug_regs_tb.sv ----
// Self-checking testbench of the media processor debug register bank.
`timescale 1ns/100ps
`include "mp_debug_consts.svh"

module media_processor_debug_regs_tb;
   logic clk, rst, ce, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, dma_req, dma_grant;
   logic mp_run, mp_reset_hold, fetch_pc_load, watch_hit;
   logic ram_rd_en, ram_wr_en, bs_watch_hit;
   logic break_stop, bs_in_xfer, bs_out_xfer, bs_mbox_rd;
   logic [15:2] fetch_pc, decode_pc;
   logic [15:0] bs_mbox_data;
   mp_debug_pkg::ls_access_t ls;
   mp_debug_pkg::exc_report_t exc;
   mp_debug_pkg::bs_access_t bs_ls;
   int err_total, samples_checked;

   media_processor_debug_regs dut (
      .clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ls, .exc,
      .break_stop, .decode_pc, .mp_run, .mp_reset_hold, .fetch_pc_load,
      .fetch_pc, .watch_hit, .dma_req, .dma_grant, .ram_rd_en, .ram_wr_en,
      .bs_ls, .bs_in_xfer, .bs_out_xfer, .bs_mbox_rd, .bs_watch_hit,
      .bs_mbox_data
   );
   mp_far_side far (
      .clk, .ls, .exc, .bs_ls, .break_stop, .bs_in_xfer, .bs_out_xfer,
      .bs_mbox_rd, .decode_pc, .dma_req
   );

   initial begin
      clk = 1'b0;
   end
   always #5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(nm, e, x);
      chk("hresp", 32'h0, 32'(hresp));
   endtask : rdc

   task automatic t_reset;
      rdc("grant", `OFF_DATA_RAM_GRANT, 32'h0);
      rdc("control", `OFF_RUN_CONTROL_STATUS, 32'h0);
      rdc("flags", `OFF_EXCEPTION_FLAGS, 32'h0);
      rdc("bits in", `OFF_BITS_IN_COUNTER, 32'h0);
      rdc("bits out", `OFF_BITS_OUT_COUNTER, 32'h0);
      rdc("mailbox", `OFF_INBOUND_MAILBOX, 32'h0);
      chk("reset hold", 32'h1, 32'(mp_reset_hold));
      wr(8'h3c, 32'hffff_ffff);
      rdc("unmapped", 8'h3c, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_grant;
      wr(`OFF_DATA_RAM_GRANT, 32'hffff_fffd);
      rdc("grant", `OFF_DATA_RAM_GRANT, 32'h5);
      far.levels(3'h7, 14'h0);
      far.step('{1'b1, 1'b0, 2'd0, 32'h40}, '0, '0, 4'h0);
      #1 chk("rd en", 32'h1, 32'(ram_rd_en));
      chk("dma granted bank", 32'h2, 32'(dma_grant));
      far.step('{1'b1, 1'b1, 2'd1, 32'h44}, '0, '0, 4'h0);
      #1 chk("wr en", 32'h0, 32'(ram_wr_en));
      chk("dma free bank", 32'h2, 32'(dma_grant));
      @(posedge clk);
      #1 chk("dma idle", 32'h7, 32'(dma_grant));
      $display("test grant done");
   endtask : t_grant

   task automatic t_run;
      wr(`OFF_RUN_CONTROL_STATUS, 32'h2);
      rdc("control", `OFF_RUN_CONTROL_STATUS, 32'h2);
      chk("reset hold", 32'h0, 32'(mp_reset_hold));
      chk("run", 32'h0, 32'(mp_run));
      wr(`OFF_PROGRAM_COUNTER, 32'h100);
      wr(`OFF_RUN_CONTROL_STATUS, 32'h3);
      rdc("control", `OFF_RUN_CONTROL_STATUS, 32'h3);
      chk("run", 32'h1, 32'(mp_run));
      far.step('0, '0, '0, 4'h8);
      rdc("break poll", `OFF_RUN_CONTROL_STATUS, 32'h2);
      chk("run", 32'h0, 32'(mp_run));
      wr(`OFF_RUN_CONTROL_STATUS, 32'h3);
      wr(`OFF_RUN_CONTROL_STATUS, 32'h0);
      rdc("control", `OFF_RUN_CONTROL_STATUS, 32'h0);
      chk("reset hold", 32'h1, 32'(mp_reset_hold));
      $display("test run done");
   endtask : t_run

   task automatic t_pc;
      far.levels(3'h0, 14'h0aa0);
      wr(`OFF_PROGRAM_COUNTER, 32'hffff_1234);
      chk("pc load", 32'h1, 32'(fetch_pc_load));
      chk("fetch pc", 32'h48d, 32'(fetch_pc));
      rdc("decode pc", `OFF_PROGRAM_COUNTER, 32'h2a80);
      $display("test pc done");
   endtask : t_pc

   task automatic t_exc;
      far.step('0, '{8'h0a, 14'h123, 1'b1, 32'hdead_beef}, '0, 4'h0);
      rdc("cause", `OFF_EXCEPTION_CAUSE, 32'h8000_0004);
      rdc("epc", `OFF_EXCEPTION_PC, 32'h48c);
      rdc("fault", `OFF_FAULT_DATA_ADDRESS, 32'hdead_beef);
      rdc("flags", `OFF_EXCEPTION_FLAGS, 32'ha);
      far.step('0, '{8'h04, 14'h1, 1'b0, 32'h0}, '0, 4'h0);
      rdc("cause held", `OFF_EXCEPTION_CAUSE, 32'h8000_0004);
      wr(`OFF_EXCEPTION_FLAGS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         far.step('0, '{8'(1 << i), 14'h0, 1'b0, 32'h0}, '0, 4'h0);
         rdc("cause code", `OFF_EXCEPTION_CAUSE, 32'(i) << 2);
         rdc("flag bit", `OFF_EXCEPTION_FLAGS, 32'h1 << i);
         wr(`OFF_EXCEPTION_FLAGS, 32'h0);
      end
      $display("test exceptions done");
   endtask : t_exc

   task automatic t_watch;
      wr(`OFF_WATCH_ADDRESS, 32'hffff_ffff);
      rdc("watch", `OFF_WATCH_ADDRESS, 32'hffff_fff8);
      far.step('{1'b1, 1'b0, 2'd3, 32'hffff_fffc}, '0, '0, 4'h0);
      #1 chk("watch hit", 32'h1, 32'(watch_hit));
      far.step('{1'b1, 1'b1, 2'd3, 32'hffff_fff0}, '0, '0, 4'h0);
      #1 chk("watch miss", 32'h0, 32'(watch_hit));
      wr(`OFF_BS_WATCH_ADDRESS, 32'h1234);
      rdc("bs watch", `OFF_BS_WATCH_ADDRESS, 32'h1234);
      far.step('0, '0, '{1'b1, 16'h1235}, 4'h0);
      #1 chk("bs hit", 32'h1, 32'(bs_watch_hit));
      far.step('0, '0, '{1'b1, 16'h1236}, 4'h0);
      #1 chk("bs miss", 32'h0, 32'(bs_watch_hit));
      $display("test watch done");
   endtask : t_watch

   task automatic t_count;
      wr(`OFF_CYCLE_COUNTER, 32'hffff_fffe);
      bus(1'b0, `OFF_CYCLE_COUNTER, 32'h0, rd);
      chk("cycle wrap", 32'h1, 32'(rd < 32'h20));
      repeat (3) far.step('0, '0, '0, 4'h4);
      rdc("bits in", `OFF_BITS_IN_COUNTER, 32'h3);
      wr(`OFF_BITS_OUT_COUNTER, 32'h00ff_ffff);
      far.step('0, '0, '0, 4'h2);
      rdc("bits out", `OFF_BITS_OUT_COUNTER, 32'h0);
      $display("test counters done");
   endtask : t_count

   task automatic t_mbox;
      wr(`OFF_INBOUND_MAILBOX, 32'h0000_1234);
      rdc("mailbox", `OFF_INBOUND_MAILBOX, 32'h9234);
      far.step('0, '0, '0, 4'h1);
      #1 chk("bs read", 32'h9234, 32'(bs_mbox_data));
      rdc("mailbox", `OFF_INBOUND_MAILBOX, 32'h1234);
      far.step('0, '0, '0, 4'h1);
      #1 chk("bs read", 32'h1234, 32'(bs_mbox_data));
      $display("test mailbox done");
   endtask : t_mbox

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      {rst, ce, hsel, hwrite, htrans} = 6'h30;
      {haddr, hwdata, hsize} = {64'h0, 3'h2};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_grant;
      t_run;
      t_pc;
      t_exc;
      t_watch;
      t_count;
      t_mbox;
      end_sim;
   end

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      end_sim;
   end
endmodule : media_processor_debug_regs_tb
